/* File: pkg/timer_pair_pkg.sv */
package timer_pair_pkg;

  // Bus shape.
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int SEL_W = 4;
  localparam int ADR_LSB = 2;
  localparam int IDX_W = 8;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [31:0] FFCR_IDX = 32'hFFFFF12D;
  localparam logic [7:0] OUTPUT_FLIPFLOP_CONTROL_B_IDX = FFCR_IDX[7:0];
  localparam logic [7:0] PAIR_RUN_REGISTER_IDX = 8'h28;
  localparam logic [7:0] PAIR_MODE_REGISTER_IDX = 8'h29;
  localparam logic [7:0] LOWER_COMPARE_REGISTER_IDX = 8'h2A;
  localparam logic [7:0] UPPER_COMPARE_REGISTER_IDX = 8'h2B;
  localparam logic [7:0] PAIR_STATUS_IDX = 8'h2C;

  // Field positions.
  localparam int RUN_LO_BIT = 0;
  localparam int RUN_UP_BIT = 1;
  localparam int MODE_LCLK_LSB = 0;
  localparam int MODE_UCLK_LSB = 2;
  localparam int MODE_PAIR_LSB = 6;
  localparam int FF_SRC_BIT = 0;
  localparam int FF_EN_BIT = 1;
  localparam int FF_ACT_LSB = 2;
  localparam int STAT_UP_LSB = 8;
  localparam int STAT_FF_BIT = 16;
  localparam int STAT_SUSP_BIT = 17;

  // Codes.
  localparam logic [1:0] PAIR_8BIT = 2'b00;
  localparam logic [1:0] PAIR_16BIT = 2'b01;
  localparam logic [1:0] ACT_TOGGLE = 2'b00;
  localparam logic [1:0] ACT_SET = 2'b01;
  localparam logic [1:0] ACT_CLEAR = 2'b10;
  localparam logic [1:0] ACT_NONE = 2'b11;
  localparam logic [1:0] LCLK_PIN = 2'b00;
  localparam logic [1:0] LCLK_DIV1 = 2'b01;
  localparam logic [1:0] LCLK_DIV4 = 2'b10;
  localparam logic [1:0] LCLK_DIV16 = 2'b11;
  localparam logic [1:0] UCLK_MATCH = 2'b00;
  localparam logic [1:0] UCLK_DIV1 = 2'b01;
  localparam logic [1:0] UCLK_DIV16 = 2'b10;
  localparam logic [1:0] UCLK_DIV256 = 2'b11;

  // Reset values.
  localparam logic [1:0] RUN_RST = 2'b00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic FF_EN_RST = 1'b0;
  localparam logic FF_SRC_RST = 1'b0;
  localparam logic FF_RST = 1'b0;
  localparam logic [7:0] PRE_RST = 8'h00;

  // Prescaler tap masks: a tap fires when all masked bits are ones.
  localparam logic [7:0] DIV4_MASK = 8'h03;
  localparam logic [7:0] DIV16_MASK = 8'h0F;
  localparam logic [7:0] DIV256_MASK = 8'hFF;

endpackage

/* File: pkg/timer_cnt_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface timer_cnt_if;
  logic run;
  logic tick;
  logic clear;
  logic [7:0] cmp;
  logic [7:0] count;
  logic match;
  logic equal;
  logic ovf;
  modport ctl (output run, output tick, output clear, output cmp,
               input count, input match, input equal, input ovf);
  modport cnt (input run, input tick, input clear, input cmp,
               output count, output match, output equal, output ovf);
endinterface // timer_cnt_if
`default_nettype wire

/* File: rtl/timer_counter8.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_counter8 (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Counter control and state
  timer_cnt_if.cnt port_io
);
  logic [7:0] count_r;
  logic match_r;
  logic ovf_r;
  logic [7:0] base;
  logic [7:0] count_nxt;

  // A clear that meets a tick restarts at one, so the period stays at cmp ticks.
  always_comb begin
    base = port_io.clear ? 8'h00 : count_r;
    count_nxt = port_io.tick ? 8'(base + 8'h01) : base;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !port_io.run) begin
      count_r <= 8'h00;
      match_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      match_r <= port_io.tick && (count_nxt == port_io.cmp);
      ovf_r <= port_io.tick && !port_io.clear && (count_r == 8'hFF);
    end
  end

  assign port_io.count = count_r;
  assign port_io.match = match_r;
  assign port_io.ovf = ovf_r;
  assign port_io.equal = (count_r == port_io.cmp);

  a_halt_zeroes: assert property (@(posedge clk_i) disable iff (rst_i)
    !port_io.run |=> count_r == 8'h00) else $error("halted counter not zero");

endmodule // timer_counter8
`default_nettype wire

/* File: rtl/timer_pair.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Action field toggles, sets, clears, ignores; reads ones.
// - Source bit picks lower or upper match, 8-bit only.
// - Control bits 7 to 4 unused, read zero.
// - In 8-bit mode both timers run independently.
// - Upper timer interrupts every compare times clock period.
// - Run bit low halts and zeroes counter; high counts.
// - Lower: pin, div1/4/16; upper: match, div1/16/256.
// - Enabled match toggles output, giving square wave.
// - Upper timer may count lower timer matches.
// - Pair mode field 01 selects cascaded 16-bit.
// - In 16-bit, upper clocked by lower overflow.
// - Lower compare low byte, upper compare high byte.
// - Lower compare write suspends compare until upper write.
// - 16-bit lower match: no clear, no lower interrupt.
// - 16-bit joint match clears both, raises upper interrupt.
// - 16-bit joint match toggles output when enabled.
// - Reset: action reads 11, enable and source zero.
// - Toggle enable bit blocks or allows match toggling.
module timer_pair (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [timer_pair_pkg::ADDR_W-1:0] adr_i,
  input wire logic [timer_pair_pkg::SEL_W-1:0] sel_i,
  input wire logic [timer_pair_pkg::DATA_W-1:0] dat_i,
  output logic [timer_pair_pkg::DATA_W-1:0] dat_o,
  output logic ack_o,
  // Timer pins and interrupt requests
  input wire logic timer_input_pin_i,
  output logic timer_output_pin_o,
  output logic lower_timer_irq_o,
  output logic upper_timer_irq_o
);
  import timer_pair_pkg::*;

  timer_cnt_if lo_if ();
  timer_cnt_if up_if ();

  logic ack_r;
  logic [DATA_W-1:0] dat_r;
  logic [1:0] run_r;
  logic [7:0] mode_r;
  logic [7:0] cmp_lo_r;
  logic [7:0] cmp_up_r;
  logic ff_en_r;
  logic ff_src_r;
  logic suspend_r;
  logic ff_r;
  logic lo_irq_r;
  logic up_irq_r;
  logic [7:0] pre_r;
  logic pin_prev_r;

  logic bus_req;
  logic [IDX_W-1:0] idx;
  logic wr_stb;
  logic wr_run;
  logic wr_mode;
  logic wr_lcmp;
  logic wr_ucmp;
  logic wr_ffcr;
  logic [1:0] ff_act;
  logic [DATA_W-1:0] rd_mux;
  logic [1:0] lclk_sel;
  logic [1:0] uclk_sel;
  logic is_16;
  logic tap_div4;
  logic tap_div16;
  logic tap_div256;
  logic pin_rise;
  logic lo_tick;
  logic up_tick;
  logic lo_match8;
  logic up_match8;
  logic match16;
  logic ff_toggle;

  // Bus decode. A write lands on the edge where the master sees ack high.
  assign bus_req = cyc_i && stb_i;
  assign idx = adr_i[ADR_LSB +: IDX_W];
  assign wr_stb = bus_req && we_i && ack_r && sel_i[0];
  assign wr_run = wr_stb && (idx == PAIR_RUN_REGISTER_IDX);
  assign wr_mode = wr_stb && (idx == PAIR_MODE_REGISTER_IDX);
  assign wr_lcmp = wr_stb && (idx == LOWER_COMPARE_REGISTER_IDX);
  assign wr_ucmp = wr_stb && (idx == UPPER_COMPARE_REGISTER_IDX);
  assign wr_ffcr = wr_stb && (idx == OUTPUT_FLIPFLOP_CONTROL_B_IDX);
  assign ff_act = dat_i[FF_ACT_LSB +: 2];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req && !ack_r;
    end
  end

  // Unused control bits 7 to 4 and unmapped words read as zero.
  always_comb begin
    rd_mux = '0;
    case (idx)
      PAIR_RUN_REGISTER_IDX: rd_mux[1:0] = run_r;
      PAIR_MODE_REGISTER_IDX: rd_mux[7:0] = mode_r;
      LOWER_COMPARE_REGISTER_IDX: rd_mux[7:0] = cmp_lo_r;
      UPPER_COMPARE_REGISTER_IDX: rd_mux[7:0] = cmp_up_r;
      PAIR_STATUS_IDX: begin
        rd_mux[7:0] = lo_if.count;
        rd_mux[STAT_UP_LSB +: 8] = up_if.count;
        rd_mux[STAT_FF_BIT] = ff_r;
        rd_mux[STAT_SUSP_BIT] = suspend_r;
      end
      OUTPUT_FLIPFLOP_CONTROL_B_IDX: begin
        rd_mux[FF_ACT_LSB +: 2] = ACT_NONE;
        rd_mux[FF_EN_BIT] = ff_en_r;
        rd_mux[FF_SRC_BIT] = ff_src_r;
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= '0;
    end else if (bus_req && !ack_r) begin
      dat_r <= rd_mux;
    end
  end

  // Software registers. Halting before reprogramming is left to software.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= RUN_RST;
    end else if (wr_run) begin
      run_r <= dat_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= MODE_RST;
    end else if (wr_mode) begin
      mode_r <= dat_i[7:0];
    end
  end

  // Lower compare holds the low byte and upper compare the high byte in 16-bit mode.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_lo_r <= CMP_RST;
      cmp_up_r <= CMP_RST;
    end else begin
      if (wr_lcmp) begin
        cmp_lo_r <= dat_i[7:0];
      end
      if (wr_ucmp) begin
        cmp_up_r <= dat_i[7:0];
      end
    end
  end

  // Keeps a half-written 16-bit compare value from firing a false match.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      suspend_r <= 1'b0;
    end else if (wr_lcmp) begin
      suspend_r <= 1'b1;
    end else if (wr_ucmp) begin
      suspend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ff_en_r <= FF_EN_RST;
      ff_src_r <= FF_SRC_RST;
    end else if (wr_ffcr) begin
      ff_en_r <= dat_i[FF_EN_BIT];
      ff_src_r <= dat_i[FF_SRC_BIT];
    end
  end

  // Prescaler taps and the timer input pin edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_r <= PRE_RST;
      pin_prev_r <= 1'b0;
    end else begin
      pre_r <= 8'(pre_r + 8'h01);
      pin_prev_r <= timer_input_pin_i;
    end
  end

  assign tap_div4 = (pre_r & DIV4_MASK) == DIV4_MASK;
  assign tap_div16 = (pre_r & DIV16_MASK) == DIV16_MASK;
  assign tap_div256 = (pre_r & DIV256_MASK) == DIV256_MASK;
  assign pin_rise = timer_input_pin_i && !pin_prev_r;

  assign lclk_sel = mode_r[MODE_LCLK_LSB +: 2];
  assign uclk_sel = mode_r[MODE_UCLK_LSB +: 2];
  assign is_16 = mode_r[MODE_PAIR_LSB +: 2] == PAIR_16BIT;

  always_comb begin
    case (lclk_sel)
      LCLK_PIN: lo_tick = pin_rise;
      LCLK_DIV1: lo_tick = 1'b1;
      LCLK_DIV4: lo_tick = tap_div4;
      LCLK_DIV16: lo_tick = tap_div16;
      default: lo_tick = 1'b0;
    endcase
  end

  always_comb begin
    if (is_16) begin
      up_tick = lo_if.ovf;
    end else begin
      case (uclk_sel)
        UCLK_MATCH: up_tick = lo_match8;
        UCLK_DIV1: up_tick = 1'b1;
        UCLK_DIV16: up_tick = tap_div16;
        UCLK_DIV256: up_tick = tap_div256;
        default: up_tick = 1'b0;
      endcase
    end
  end

  // Compare events of each mode.
  assign lo_match8 = !is_16 && lo_if.match;
  assign up_match8 = !is_16 && up_if.match;
  assign match16 = is_16 && !suspend_r && lo_if.match && up_if.equal;

  assign lo_if.run = run_r[RUN_LO_BIT];
  assign lo_if.tick = lo_tick;
  assign lo_if.cmp = cmp_lo_r;
  assign lo_if.clear = lo_match8 || match16;
  assign up_if.run = run_r[RUN_UP_BIT];
  assign up_if.tick = up_tick;
  assign up_if.cmp = cmp_up_r;
  assign up_if.clear = up_match8 || match16;

  timer_counter8 lower_up_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .port_io(lo_if.cnt)
  );

  timer_counter8 upper_up_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .port_io(up_if.cnt)
  );

  // Interrupt requests are one-cycle pulses.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lo_irq_r <= 1'b0;
      up_irq_r <= 1'b0;
    end else begin
      lo_irq_r <= lo_match8;
      up_irq_r <= up_match8 || match16;
    end
  end

  // A software action beats a match toggle in the same cycle, so the action is never lost.
  assign ff_toggle = is_16 ? match16 : (ff_src_r ? up_match8 : lo_match8);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ff_r <= FF_RST;
    end else if (wr_ffcr && (ff_act != ACT_NONE)) begin
      case (ff_act)
        ACT_TOGGLE: ff_r <= !ff_r;
        ACT_SET: ff_r <= 1'b1;
        ACT_CLEAR: ff_r <= 1'b0;
        default: ff_r <= ff_r;
      endcase
    end else if (ff_en_r && ff_toggle) begin
      ff_r <= !ff_r;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign timer_output_pin_o = ff_r;
  assign lower_timer_irq_o = lo_irq_r;
  assign upper_timer_irq_o = up_irq_r;

  a_action_reads_ones: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && !we_i && (idx == OUTPUT_FLIPFLOP_CONTROL_B_IDX) |-> dat_o[FF_ACT_LSB +: 2] == 2'b11)
    else $error("action field did not read ones");

  a_soft_set_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ffcr && (ff_act == ACT_SET || ff_act == ACT_CLEAR) |=> timer_output_pin_o == $past(ff_act == ACT_SET))
    else $error("soft set or clear missed the output");

  a_source_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    !is_16 && ff_en_r && ff_src_r && up_if.match && !lo_if.match && !wr_ffcr
    |=> timer_output_pin_o != $past(timer_output_pin_o))
    else $error("upper match did not toggle the output");

  a_toggle_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
    !ff_en_r && !wr_ffcr |=> $stable(timer_output_pin_o))
    else $error("output moved with toggling disabled");

  a_match_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    lo_match8 && lo_if.run ##1 lo_if.run |-> lo_if.count <= 8'h01 && lower_timer_irq_o)
    else $error("8-bit match did not clear and interrupt");

  a_lower_quiet16: assert property (@(posedge clk_i) disable iff (rst_i)
    is_16 && lo_if.match && !match16 && lo_if.run && lo_if.tick
    |=> !lower_timer_irq_o && lo_if.count == 8'($past(lo_if.count) + 8'h01))
    else $error("16-bit lower match cleared or interrupted");

  a_split_compare: assert property (@(posedge clk_i) disable iff (rst_i)
    match16 |-> lo_if.count == cmp_lo_r && up_if.count == cmp_up_r)
    else $error("joint match away from the split compare value");

  a_upper_on_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
    is_16 && up_if.run && !up_if.clear |=> up_if.count == 8'($past(up_if.count) + {7'h00, $past(lo_if.ovf)}))
    else $error("16-bit upper count did not follow lower overflow");

  a_joint_match: assert property (@(posedge clk_i) disable iff (rst_i)
    match16 && lo_if.run && up_if.run ##1 lo_if.run && up_if.run
    |-> upper_timer_irq_o && lo_if.count <= 8'h01 && up_if.count <= 8'h01)
    else $error("joint match did not clear both and interrupt");

  a_suspend_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    is_16 && wr_lcmp |=> ##1 !upper_timer_irq_o)
    else $error("compare not suspended after lower write");

  a_ctl_reset: assert property (@(posedge clk_i)
    rst_i |=> !ff_en_r && !ff_src_r && !timer_output_pin_o)
    else $error("control bits not cleared by reset");

endmodule // timer_pair
`default_nettype wire

/* File: sim/timer_pair_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_pair_bench;
  import timer_pair_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [ADDR_W-1:0] adr_i = '0;
  logic [SEL_W-1:0] sel_i = '0;
  logic [DATA_W-1:0] dat_i = '0;
  logic [DATA_W-1:0] dat_o;
  logic ack_o;
  logic timer_input_pin_i = 1'b0;
  logic timer_output_pin_o;
  logic lower_timer_irq_o;
  logic upper_timer_irq_o;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  logic [1:0] lo_code[3] = '{LCLK_DIV1, LCLK_DIV4, LCLK_DIV16};
  logic [1:0] up_code[3] = '{UCLK_DIV1, UCLK_DIV16, UCLK_DIV256};
  int lo_mul[3] = '{1, 4, 16};
  int up_mul[3] = '{1, 16, 256};
  logic [1:0] act[5] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_NONE, ACT_TOGGLE};
  logic act_ff[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  always #25 clk_i = ~clk_i;

  timer_pair timer_pair_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .timer_input_pin_i(timer_input_pin_i),
    .timer_output_pin_o(timer_output_pin_o),
    .lower_timer_irq_o(lower_timer_irq_o),
    .upper_timer_irq_o(upper_timer_irq_o)
  );

  task automatic give_verdict;
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Read data is judged where it appears, against the oldest note left by the driver.
  always @(negedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      if (exp_q.size() == 0) begin
        chk("read without note", 32'h0, 32'h1);
      end else begin
        chk("dat_o", exp_q.pop_front(), dat_o & mask_q.pop_front());
      end
    end
  end

  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] data, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= {22'h0, idx, 2'b00};
    sel_i <= sel;
    dat_i <= data;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    if (n >= 100) chk("ack_o", 32'h1, 32'h0);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    logic [2:0] hi;
    hi = 3'($urandom_range(7, 0));
    bus(idx, 1'b1, {24'h0, data}, {hi, 1'b1});
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] mask);
    exp_q.push_back(exp & mask);
    mask_q.push_back(mask);
    bus(idx, 1'b0, 32'h0, 4'hF);
  endtask

  // Compares are always written lower before upper, as the cascade demands.
  task automatic cfg(input logic [7:0] mode, input logic [7:0] lc, input logic [7:0] uc,
                     input logic [7:0] ff, input logic [1:0] run);
    wr(PAIR_RUN_REGISTER_IDX, 8'h00);
    wr(PAIR_MODE_REGISTER_IDX, mode);
    wr(LOWER_COMPARE_REGISTER_IDX, lc);
    wr(UPPER_COMPARE_REGISTER_IDX, uc);
    wr(OUTPUT_FLIPFLOP_CONTROL_B_IDX, ff);
    wr(PAIR_RUN_REGISTER_IDX, {6'h0, run});
  endtask

  function automatic logic irq(input bit u);
    return u ? upper_timer_irq_o : lower_timer_irq_o;
  endfunction

  // Measures between two pulses, since the first one depends on the prescaler phase.
  task automatic per(input bit u, input int exp, input bit tog);
    int n;
    logic o0;
    n = 0;
    while (irq(u) !== 1'b1 && n < 20000) begin
      @(negedge clk_i);
      n++;
    end
    o0 = timer_output_pin_o;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (irq(u) !== 1'b1 && n < 20000);
    chk(u ? "upper period" : "lower period", exp, n);
    chk("timer_output_pin_o", {31'h0, tog ? ~o0 : o0}, {31'h0, timer_output_pin_o});
  endtask

  task automatic quiet(input bit u, input int cycles);
    logic hit;
    hit = 1'b0;
    repeat (cycles) begin
      @(negedge clk_i);
      if (irq(u) === 1'b1) hit = 1'b1;
    end
    chk("irq quiet", 32'h0, {31'h0, hit});
  endtask

  initial begin
    repeat (50000) @(posedge clk_i);
    err_count++;
    give_verdict;
  end

  initial begin
    int c;
    int b;
    void'($urandom(32'h1900c989));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OUTPUT_FLIPFLOP_CONTROL_B_IDX, 32'hC, 32'hF);
    rd(PAIR_RUN_REGISTER_IDX, 32'h0, 32'h3);
    rd(PAIR_MODE_REGISTER_IDX, 32'h0, 32'hFF);
    rd(PAIR_STATUS_IDX, 32'h0, 32'h3FFFF);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    foreach (act[i]) begin
      wr(OUTPUT_FLIPFLOP_CONTROL_B_IDX, {4'h0, act[i], 2'b00});
      rd(PAIR_STATUS_IDX, {15'h0, act_ff[i], 16'h0}, 32'h10000);
      rd(OUTPUT_FLIPFLOP_CONTROL_B_IDX, 32'hC, 32'hF);
    end
    // A write without its low byte lane must leave the flip-flop alone.
    bus(OUTPUT_FLIPFLOP_CONTROL_B_IDX, 1'b1, 32'h4, 4'hE);
    rd(PAIR_STATUS_IDX, 32'h0, 32'h10000);
    for (int u = 0; u < 2; u++) begin
      for (int k = 0; k < 3; k++) begin
        c = u ? $urandom_range(4, 2) : $urandom_range(20, 2);
        if (u == 0) begin
          cfg({6'h0, lo_code[k]}, 8'(c), 8'h00, 8'h0A, 2'b01);
          per(0, c * lo_mul[k], 1'b1);
        end else begin
          cfg({4'h0, up_code[k], 2'b00}, 8'h00, 8'(c), 8'h0B, 2'b10);
          per(1, c * up_mul[k], 1'b1);
        end
      end
    end
    wr(PAIR_RUN_REGISTER_IDX, 8'h00);
    rd(PAIR_STATUS_IDX, 32'h0, 32'hFFFF);
    cfg({6'h0, LCLK_DIV1}, 8'h05, 8'h00, 8'h08, 2'b01);
    per(0, 5, 1'b0);
    cfg({6'h0, LCLK_DIV1}, 8'h05, 8'h00, 8'h0B, 2'b01);
    per(0, 5, 1'b0);
    c = $urandom_range(9, 2);
    b = $urandom_range(5, 2);
    cfg({4'h0, UCLK_MATCH, LCLK_DIV1}, 8'(c), 8'(b), 8'h0A, 2'b11);
    per(0, c, 1'b1);
    per(1, c * b, b[0]);
    c = $urandom_range(60, 1);
    cfg({PAIR_16BIT, 2'b00, UCLK_DIV1, LCLK_DIV1}, 8'(c), 8'h01, 8'h0A, 2'b11);
    per(1, 256 + c, 1'b1);
    quiet(0, 600);
    wr(PAIR_RUN_REGISTER_IDX, 8'h00);
    wr(LOWER_COMPARE_REGISTER_IDX, 8'h10);
    rd(PAIR_STATUS_IDX, 32'h20000, 32'h20000);
    wr(UPPER_COMPARE_REGISTER_IDX, 8'h01);
    rd(PAIR_STATUS_IDX, 32'h0, 32'h20000);
    cfg({6'h0, LCLK_PIN}, 8'hC8, 8'h00, 8'h0C, 2'b01);
    c = $urandom_range(6, 1);
    repeat (c) begin
      @(posedge clk_i);
      timer_input_pin_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      timer_input_pin_i <= 1'b0;
      @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
    rd(PAIR_STATUS_IDX, 32'(c), 32'hFF);
    repeat (4) @(posedge clk_i);
    give_verdict;
  end
endmodule // timer_pair_bench
`default_nettype wire
